// [include/spc_defines.svh]
// Register indices, field positions and reset values of the serial port
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH
// Register indices; byte address is four times the index
`define SPC_IDX_DATA     12'hF60
`define SPC_IDX_SELECT   12'hF61
`define SPC_IDX_CTRL     12'hF62
`define SPC_IDX_MODE     12'hF63
`define SPC_IDX_STATUS   12'hF64
`define SPC_IDX_RATE_HI  12'hF66
`define SPC_IDX_RATE_LO  12'hF67
`define SPC_IDX_IRQ_ST   12'hF68
`define SPC_IDX_IRQ_MASK 12'hF69
// Field positions
`define SPC_ST_TX_EMPTY  7
`define SPC_ST_RX_FULL   2
`define SPC_IRQ_TIMEOUT  0
`define SPC_IRQ_ABORT    1
`define SPC_IRQ_RX_CHAR  2
`define SPC_PIN_SCK      3
`define SPC_PIN_SS       2
`define SPC_PIN_MOSI     1
`define SPC_PIN_MISO     0
// Reset values
`define SPC_CTRL_RST     8'h00
`define SPC_MODE_RST     8'h00
`define SPC_RATE_RST     16'h0000
`define SPC_IRQ_RST      3'h0
// Bus answers
`define SPC_RESP_OKAY    2'h0
`define SPC_RESP_SLVERR  2'h2
`endif

// [include/spc_pkg.sv]
// Types shared by the serial port configuration block
package spc_pkg;
  typedef struct packed {
    logic irq_en;
    logic enable_dir_hi;
    logic rate_gen_ctl;
    logic phase_sel;
    logic clock_polarity_sel;
    logic open_drain_sel;
    logic controller_mode_en;
    logic enable_dir_lo;
  } spc_ctrl_type;

  typedef struct packed {
    logic [2:0] select_framing_mode;
    logic [2:0] char_length;
    logic       select_pin_direction;
    logic       select_pin_polarity;
  } spc_mode_type;

  typedef struct packed {
    logic sck;
    logic ss;
    logic mosi;
    logic miso;
  } spc_pins_type;

  typedef enum logic [1:0] {
    SPC_IDLE = 2'b01,
    SPC_BUSY = 2'b10
  } spc_xfer_type;
endpackage

// [logic/spc_serial_port.sv]
// Serial port control, mode, rate generator and pin logic with AXI4-Lite
// What this block does
// - With both enable bits zero the port is off; generator may run as timer.
// - Receive-only: transmit-empty never asserts, every bit sent is one.
// - Transmit-only: receive-not-empty never asserts.
// - Full duplex: transmit-empty and receive-not-empty both work normally.
// - Port off: generator bit clear stops timer, reads give reload; set runs.
// - Port on: generator bit selects reload or live counter on reads.
// - Port on as controller: generator always runs and makes the clock.
// - Port on as peripheral: generator off if bit clear, else clock time-out.
// - Phase bit picks which clock edge launches data and which samples it.
// - Open-drain bit makes all four pins drive low only, release high.
// - Controller bit clear: data out on MISO, in on MOSI, clock input.
// - Controller bit set: data out on MOSI, in on MISO, clock output.
// - Mode register: framing 7:5, length 4:2, select dir 1, polarity 0.
// - Length code zero shifts eight bits, other codes shift that many.
// - Select polarity bit makes select active low at zero, high at one.
`timescale 1ns/100ps
`default_nettype none
`include "spc_defines.svh"

module spc_serial_port #(
  parameter int ADDR_W = 14
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic [2:0]           s_axi_awprot,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic [2:0]           s_axi_arprot,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Serial pins
  input  wire spc_pkg::spc_pins_type pin_in,
  output var  spc_pkg::spc_pins_type pin_out,
  output var  spc_pkg::spc_pins_type pin_oe_n,
  // Interrupt
  output logic                      irq
);
  import spc_pkg::*;

  function automatic logic [11:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = 12'(a >> 2);
  endfunction

  function automatic logic mapped(input logic [11:0] i);
    mapped = (i >= `SPC_IDX_DATA && i <= `SPC_IDX_STATUS) ||
             (i >= `SPC_IDX_RATE_HI && i <= `SPC_IDX_IRQ_MASK);
  endfunction

  function automatic logic [3:0] char_bits(input logic [2:0] code);
    char_bits = (code == 3'h0) ? 4'h8 : {1'b0, code};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  spc_ctrl_type     ctrl;
  spc_mode_type     mode;
  spc_xfer_type     state;
  logic [15:0]      reload;
  logic [15:0]      count;
  logic             sel_value;
  logic [7:0]       tx_data;
  logic             tx_full;
  logic [7:0]       rx_data;
  logic [7:0]       rx_sh;
  logic             rx_full;
  logic [7:0]       tx_sh;
  logic             dout;
  logic             sck_q;
  logic             sel_q;
  logic [3:0]       bit_cnt;
  logic [4:0]       edge_cnt;
  logic [2:0]       irq_st;
  logic [2:0]       irq_mask;
  logic [3:0]       pin_meta;
  logic [3:0]       pin_sync;
  logic [3:0]       pin_prev;
  logic [3:0]       po;
  logic [3:0]       poe;
  logic             aw_held;
  logic             w_held;
  logic [11:0]      aw_idx;
  logic [7:0]       w_byte;
  logic             w_lane;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: address and data taken in either order, one write at a time
  logic do_write;
  logic rd_take;
  logic [11:0] ar_idx;
  logic [7:0] rd_val;
  logic [15:0] rate_view;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_write      = aw_held & w_held & ~s_axi_bvalid;
  assign rd_take       = s_axi_arvalid & s_axi_arready;
  assign ar_idx        = reg_index(s_axi_araddr);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_held <= 1'b0;
      aw_idx  <= 12'h000;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_idx  <= reg_index(s_axi_awaddr);
    end
    else if (do_write)
      aw_held <= 1'b0;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_byte <= s_axi_wdata[7:0];
      w_lane <= s_axi_wstrb[0];
    end
    else if (do_write)
      w_held <= 1'b0;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SPC_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(aw_idx) ? `SPC_RESP_OKAY : `SPC_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  logic wr_ok;
  assign wr_ok = do_write & w_lane;

  // Rate registers show reload or live count
  assign rate_view = ctrl.rate_gen_ctl ? count : reload;

  always_comb
  begin
    unique case (ar_idx)
      `SPC_IDX_DATA:     rd_val = rx_data;
      `SPC_IDX_SELECT:   rd_val = {7'h00, sel_value};
      `SPC_IDX_CTRL:     rd_val = ctrl;
      `SPC_IDX_MODE:     rd_val = mode;
      `SPC_IDX_STATUS:   rd_val = {ctrl.enable_dir_hi & ~tx_full, 4'h0,
                                   rx_full & ctrl.enable_dir_lo, 2'h0};
      `SPC_IDX_RATE_HI:  rd_val = rate_view[15:8];
      `SPC_IDX_RATE_LO:  rd_val = rate_view[7:0];
      `SPC_IDX_IRQ_ST:   rd_val = {5'h00, irq_st};
      `SPC_IDX_IRQ_MASK: rd_val = {5'h00, irq_mask};
      default:           rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `SPC_RESP_OKAY;
    end
    else if (rd_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_val};
      s_axi_rresp  <= mapped(ar_idx) ? `SPC_RESP_OKAY : `SPC_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ctrl <= `SPC_CTRL_RST;
    else if (wr_ok && aw_idx == `SPC_IDX_CTRL)
      ctrl <= w_byte;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      mode <= `SPC_MODE_RST;
    else if (wr_ok && aw_idx == `SPC_IDX_MODE)
      mode <= w_byte;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      reload <= `SPC_RATE_RST;
    else if (wr_ok && aw_idx == `SPC_IDX_RATE_HI)
      reload[15:8] <= w_byte;
    else if (wr_ok && aw_idx == `SPC_IDX_RATE_LO)
      reload[7:0] <= w_byte;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sel_value <= 1'b0;
      irq_mask  <= `SPC_IRQ_RST;
    end
    else if (wr_ok && aw_idx == `SPC_IDX_SELECT)
      sel_value <= w_byte[0];
    else if (wr_ok && aw_idx == `SPC_IDX_IRQ_MASK)
      irq_mask <= w_byte[2:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; second stage is used, third stage only for clock edge detection
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      // Released level, so no false clock or select edge follows reset
      pin_meta <= 4'hF;
      pin_sync <= 4'hF;
      pin_prev <= 4'hF;
    end
    else
    begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock edges and transfer control
  logic enabled;
  logic is_ctl;
  logic rate_run;
  logic rate_tick;
  logic sel_active;
  logic edge_ev;
  logic leading;
  logic sample_ev;
  logic launch_ev;
  logic [3:0] bits;
  logic char_done;
  logic go_ctl;
  logic sel_rise;
  logic load_first;
  logic load_ev;
  logic take_tx;
  logic [7:0] load_val;
  logic din;

  assign enabled  = ctrl.enable_dir_hi | ctrl.enable_dir_lo;
  assign is_ctl   = ctrl.controller_mode_en;
  // Controller always needs the generator; otherwise the bit decides
  assign rate_run = enabled ? (is_ctl | ctrl.rate_gen_ctl)
                            : ctrl.rate_gen_ctl;
  assign rate_tick  = rate_run & (count == 16'h0000);
  assign sel_active = pin_sync[`SPC_PIN_SS] ==
                      mode.select_pin_polarity;
  assign edge_ev = is_ctl ? (state == SPC_BUSY) & rate_tick
                          : (state == SPC_BUSY) & sel_active &
                            (pin_sync[`SPC_PIN_SCK] != pin_prev[`SPC_PIN_SCK]);
  assign leading = is_ctl ? (sck_q == ctrl.clock_polarity_sel)
                          : (pin_prev[`SPC_PIN_SCK] == ctrl.clock_polarity_sel);
  assign sample_ev = edge_ev & (leading ^ ctrl.phase_sel);
  assign launch_ev = edge_ev & ~(leading ^ ctrl.phase_sel);
  assign bits      = char_bits(mode.char_length);
  assign char_done = sample_ev & (bit_cnt == bits - 4'h1);
  // A controller in receive-only never starts: it has nothing to send
  assign go_ctl    = (state == SPC_IDLE) & enabled & is_ctl &
                     ctrl.enable_dir_hi & tx_full;
  assign sel_rise  = (state == SPC_IDLE) & enabled & ~is_ctl &
                     sel_active & ~sel_q;
  assign load_first = go_ctl | sel_rise;
  assign load_ev   = load_first | (char_done & ~is_ctl);
  assign take_tx   = load_ev & tx_full & ctrl.enable_dir_hi;
  assign load_val  = 8'((take_tx ? tx_data : 8'hFF) << (4'h8 - bits));
  assign din       = is_ctl ? pin_sync[`SPC_PIN_MISO]
                            : pin_sync[`SPC_PIN_MOSI];

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state <= SPC_IDLE;
    else
    begin
      unique case (state)
        SPC_IDLE:
          if (load_first)
            state <= SPC_BUSY;
        SPC_BUSY:
          if (!enabled || (!is_ctl && !sel_active) ||
              (is_ctl && edge_ev &&
               edge_cnt == 5'({bits, 1'b0}) - 5'h01))
            state <= SPC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sck_q    <= 1'b0;
      sel_q    <= 1'b0;
      edge_cnt <= 5'h00;
      bit_cnt  <= 4'h0;
    end
    else
    begin
      sel_q <= sel_active;
      if (state == SPC_IDLE)
        sck_q <= ctrl.clock_polarity_sel;
      else if (is_ctl && edge_ev)
        sck_q <= ~sck_q;
      if (load_first)
        edge_cnt <= 5'h00;
      else if (edge_ev)
        edge_cnt <= edge_cnt + 5'h01;
      if (load_ev || char_done)
        bit_cnt <= 4'h0;
      else if (sample_ev)
        bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // Shifters; first bit is preset only when the edge that launches it
  // would otherwise already be past
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_sh <= 8'hFF;
      dout  <= 1'b1;
      rx_sh <= 8'h00;
    end
    else
    begin
      if (load_ev && load_first && !ctrl.phase_sel)
      begin
        dout  <= load_val[7];
        tx_sh <= {load_val[6:0], 1'b1};
      end
      else if (load_ev)
        tx_sh <= load_val;
      else if (launch_ev)
      begin
        dout  <= tx_sh[7];
        tx_sh <= {tx_sh[6:0], 1'b1};
      end
      if (sample_ev)
        rx_sh <= {rx_sh[6:0], din};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data buffers; a new event wins over a clear in the same cycle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_data <= 8'h00;
      tx_full <= 1'b0;
    end
    else if (wr_ok && aw_idx == `SPC_IDX_DATA)
    begin
      tx_data <= w_byte;
      tx_full <= 1'b1;
    end
    else if (take_tx || !ctrl.enable_dir_hi)
      tx_full <= 1'b0;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_data <= 8'h00;
      rx_full <= 1'b0;
    end
    else if (char_done && ctrl.enable_dir_lo)
    begin
      rx_data <= {rx_sh[6:0], din};
      rx_full <= 1'b1;
    end
    else if ((rd_take && ar_idx == `SPC_IDX_DATA) || !ctrl.enable_dir_lo)
      rx_full <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rate generator: half period of the controller clock is reload plus one
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      count <= `SPC_RATE_RST;
    else if (!rate_run || rate_tick)
      count <= reload;
    else if (enabled && (state == SPC_IDLE || (!is_ctl && edge_ev)))
      count <= reload;
    else
      count <= count - 16'h0001;
  end

  // Interrupt status, write one to clear
  logic [2:0] irq_set;
  assign irq_set[`SPC_IRQ_TIMEOUT] = rate_tick & ~enabled;
  assign irq_set[`SPC_IRQ_ABORT]   = rate_tick & enabled & ~is_ctl &
                                     (state == SPC_BUSY) &
                                     (bit_cnt != 4'h0);
  assign irq_set[`SPC_IRQ_RX_CHAR] = char_done & ctrl.enable_dir_lo;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      irq_st <= `SPC_IRQ_RST;
    else if (wr_ok && aw_idx == `SPC_IDX_IRQ_ST)
      irq_st <= (irq_st & ~w_byte[2:0]) | irq_set;
    else
      irq_st <= irq_st | irq_set;
  end

  assign irq = |(irq_st & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers; open drain never drives a high
  logic [3:0] drv;
  logic [3:0] val;
  logic       tx_bit;

  assign tx_bit = ctrl.enable_dir_hi ? dout : 1'b1;
  assign drv[`SPC_PIN_SCK]  = enabled & is_ctl;
  assign drv[`SPC_PIN_MOSI] = enabled & is_ctl;
  assign drv[`SPC_PIN_MISO] = enabled & ~is_ctl & sel_active;
  assign drv[`SPC_PIN_SS]   = enabled & mode.select_pin_direction;
  assign val[`SPC_PIN_SCK]  = sck_q;
  assign val[`SPC_PIN_MOSI] = tx_bit;
  assign val[`SPC_PIN_MISO] = tx_bit;
  assign val[`SPC_PIN_SS]   = mode.select_pin_polarity ? sel_value
                                                       : ~sel_value;

  for (genvar i = 0; i < 4; i++)
  begin : g_pin
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        po[i]  <= 1'b0;
        poe[i] <= 1'b1;
      end
      else
      begin
        po[i]  <= val[i] & ~ctrl.open_drain_sel;
        poe[i] <= ~(drv[i] & (~ctrl.open_drain_sel | ~val[i]));
      end
    end
  end

  assign pin_out  = po;
  assign pin_oe_n = poe;

  ////////////////////////////////////////////////////////////////////////////
  AST_OFF_RELEASED:
    assert property (@(posedge clk) disable iff (!nrst)
      !enabled ##1 !enabled |-> poe == 4'hF)
    else $error("pins driven while port disabled");
  AST_RXONLY_ONES:
    assert property (@(posedge clk) disable iff (!nrst)
      (ctrl.enable_dir_lo && !ctrl.enable_dir_hi && !ctrl.open_drain_sel)
      |=> po[`SPC_PIN_MISO] && po[`SPC_PIN_MOSI])
    else $error("receive-only sent a zero");
  AST_TXONLY_NO_RX:
    assert property (@(posedge clk) disable iff (!nrst)
      (!ctrl.enable_dir_lo && char_done) |=> !rx_full)
    else $error("receive flag set in transmit-only");
  AST_DUPLEX_FLAGS:
    assert property (@(posedge clk) disable iff (!nrst)
      (ctrl.enable_dir_hi && wr_ok && aw_idx == `SPC_IDX_DATA)
      |=> tx_full ##1 1'b1)
    else $error("transmit buffer not marked full");
  AST_RATE_READ:
    assert property (@(posedge clk) disable iff (!nrst)
      (rd_take && ar_idx == `SPC_IDX_RATE_LO) |=> s_axi_rdata[7:0] ==
      ($past(ctrl.rate_gen_ctl) ? $past(count[7:0]) : $past(reload[7:0])))
    else $error("rate register read wrong source");
  AST_CTL_GEN_RUNS:
    assert property (@(posedge clk) disable iff (!nrst)
      (enabled && is_ctl && count == 16'h0000) |=> count == $past(reload))
    else $error("generator did not reload for controller");
  AST_PERI_GEN_OFF:
    assert property (@(posedge clk) disable iff (!nrst)
      (enabled && !is_ctl && !ctrl.rate_gen_ctl) |=> count == $past(reload))
    else $error("generator ran as peripheral with bit clear");
  AST_TIMER_IRQ:
    assert property (@(posedge clk) disable iff (!nrst)
      (!enabled && ctrl.rate_gen_ctl && count == 16'h0000)
      |=> irq_st[`SPC_IRQ_TIMEOUT] && count == $past(reload))
    else $error("timer time-out missed");
  AST_IDLE_POLARITY:
    assert property (@(posedge clk) disable iff (!nrst)
      (state == SPC_IDLE && !ctrl.open_drain_sel) ##1
      (state == SPC_IDLE && $stable(ctrl))
      |=> po[`SPC_PIN_SCK] == $past(ctrl.clock_polarity_sel, 2))
    else $error("serial clock idle level wrong");
  AST_OPEN_DRAIN:
    assert property (@(posedge clk) disable iff (!nrst)
      ctrl.open_drain_sel |=> po == 4'h0)
    else $error("open drain pin driven high");
  AST_CTL_DIRS:
    assert property (@(posedge clk) disable iff (!nrst)
      (enabled && is_ctl && !ctrl.open_drain_sel) |=>
      !poe[`SPC_PIN_SCK] && !poe[`SPC_PIN_MOSI] && poe[`SPC_PIN_MISO])
    else $error("controller pin directions wrong");
  AST_PERI_DIRS:
    assert property (@(posedge clk) disable iff (!nrst)
      (enabled && !is_ctl) |=> poe[`SPC_PIN_SCK] && poe[`SPC_PIN_MOSI])
    else $error("peripheral drove clock or MOSI");
  AST_SELECT_LEVEL:
    assert property (@(posedge clk) disable iff (!nrst)
      (drv[`SPC_PIN_SS] && !ctrl.open_drain_sel) |=>
      po[`SPC_PIN_SS] == ($past(mode.select_pin_polarity) ~^ $past(sel_value)))
    else $error("select pin polarity wrong");
  AST_CHAR_LENGTH:
    assert property (@(posedge clk) disable iff (!nrst)
      (char_done && is_ctl) |-> edge_cnt + 5'h02 ==
      ((mode.char_length == 3'h0) ? 5'h10 : {1'b0, mode.char_length, 1'b0})
      + {4'h0, ctrl.phase_sel})
    else $error("character length wrong");
endmodule
`default_nettype wire

// [tb/spc_peer.sv]
// Behavioural serial peripheral, phase 0 and polarity 0
`timescale 1ns/100ps
`default_nettype none
module spc_peer (
  // Serial lines
  input  wire logic       sck,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  output logic            miso,
  output logic            miso_en,
  // Bytes exchanged
  input  wire logic [7:0] tx_byte,
  output logic [7:0]      rx_byte
);
  logic [7:0] shift;
  // Drives only while selected; the line floats to its pull-up otherwise
  assign miso_en = !ss_n;
  assign miso = shift[7];
  always @(negedge ss_n)
    shift = tx_byte;
  always @(posedge sck)
    if (!ss_n)
      rx_byte = {rx_byte[6:0], mosi};
  always @(negedge sck)
    if (!ss_n)
      shift = {shift[6:0], 1'b1};
endmodule
`default_nettype wire

// [tb/spc_serial_port_tb.sv]
// Self-checking bench for the serial port configuration block
`timescale 1ns/100ps
`default_nettype none
`include "spc_defines.svh"
module spc_serial_port_tb;
  import spc_pkg::*;
  logic         clk, nrst, awvalid, awready, wvalid, wready, bvalid;
  logic         bready, arvalid, arready, rvalid, rready, irq;
  logic         miso_p, miso_en;
  logic [13:0]  awaddr, araddr;
  logic [31:0]  wdata, rdata;
  logic [1:0]   bresp, rresp;
  logic [3:0]   lv;
  logic [7:0]   peer_tx, peer_rx, tx, r;
  logic [33:0]  expq[$];
  spc_pins_type pout, poe_n;
  int           fails, samples_checked;
  // Released lines read high through their pull-ups
  assign lv = poe_n | pout;
  spc_serial_port spc_serial_port_inst (.clk(clk), .nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pin_in({lv[3:1], lv[0] & (miso_p | !miso_en)}),
    .pin_out(pout), .pin_oe_n(poe_n), .irq(irq));
  spc_peer spc_peer_inst (.sck(lv[3]), .ss_n(lv[2]), .mosi(lv[1]),
    .miso(miso_p), .miso_en(miso_en), .tx_byte(peer_tx), .rx_byte(peer_rx));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [33:0] s, input logic [33:0] e);
    samples_checked++;
    if (s !== e)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task close_out;
    if (fails == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task wr(input logic [11:0] i, input logic [7:0] d);
    expq.push_back({`SPC_RESP_OKAY, 32'h0});
    @(posedge clk);
    awaddr  <= {i, 2'b00};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
  endtask
  // Expected {rresp, rdata} is queued before the request goes out
  task rd(input logic [11:0] i, input logic [33:0] e);
    expq.push_back(e);
    @(posedge clk);
    araddr  <= {i, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
  endtask
  // Pins are registered, so let them land before looking
  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task wirq;
    for (int k = 0; k < 500 && irq !== 1'b1; k++)
      @(posedge clk);
    chk(irq, 1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (rvalid && rready && expq.size() > 0)
      chk({rresp, rdata}, expq.pop_front());
    if (bvalid && bready && expq.size() > 0)
      chk({bresp, 32'h0}, expq.pop_front());
  end
  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out();
  end
  initial
  begin
    void'($urandom(32'h00AE01B8));
    {nrst, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    awaddr = 14'h0000;
    araddr = 14'h0000;
    wdata = 32'h0;
    peer_tx = 8'($urandom);
    tx = 8'($urandom);
    r = 8'h02 + 8'($urandom % 6);
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rd(`SPC_IDX_CTRL, 0);
    rd(`SPC_IDX_MODE, 0);
    rd(`SPC_IDX_STATUS, 0);
    rd(12'hF65, {2'h2, 32'h0});
    wr(`SPC_IDX_MODE, tx);
    rd(`SPC_IDX_MODE, tx);
    wr(`SPC_IDX_RATE_LO, r);
    wr(`SPC_IDX_RATE_HI, 0);
    rd(`SPC_IDX_RATE_LO, r);
    wr(`SPC_IDX_IRQ_MASK, 1);
    wr(`SPC_IDX_CTRL, 8'h20);
    wirq();
    wr(`SPC_IDX_IRQ_MASK, 0);
    chk(irq, 0);
    rd(`SPC_IDX_IRQ_ST, 1);
    wr(`SPC_IDX_CTRL, 0);
    wr(`SPC_IDX_IRQ_ST, 1);
    repeat (40) @(posedge clk);
    rd(`SPC_IDX_IRQ_ST, 0);
    // Half period of four clocks gives the 320 ns serial clock
    wr(`SPC_IDX_RATE_LO, 3);
    wr(`SPC_IDX_MODE, 8'h02);
    wr(`SPC_IDX_CTRL, 8'h43);
    wr(`SPC_IDX_SELECT, 1);
    wr(`SPC_IDX_IRQ_MASK, 4);
    settle();
    chk({poe_n.sck, poe_n.mosi, poe_n.miso, pout.sck}, 4'h2);
    wr(`SPC_IDX_DATA, tx);
    wirq();
    settle();
    chk(peer_rx, tx);
    rd(`SPC_IDX_DATA, peer_tx);
    rd(`SPC_IDX_STATUS, 8'h80);
    // Transmit-only controller, five-bit characters: low bits go out
    wr(`SPC_IDX_CTRL, 8'h42);
    wr(`SPC_IDX_MODE, 8'h16);
    wr(`SPC_IDX_DATA, tx);
    repeat (60) @(posedge clk);
    chk(peer_rx[4:0], tx[4:0]);
    rd(`SPC_IDX_STATUS, 8'h80);
    wr(`SPC_IDX_CTRL, 8'h4B);
    settle();
    chk(pout.sck, 1);
    wr(`SPC_IDX_CTRL, 8'h47);
    settle();
    chk(pout, 0);
    wr(`SPC_IDX_CTRL, 8'h40);
    rd(`SPC_IDX_STATUS, 8'h80);
    wr(`SPC_IDX_CTRL, 8'h01);
    rd(`SPC_IDX_STATUS, 0);
    settle();
    chk({poe_n.sck, poe_n.mosi}, 2'h3);
    close_out();
  end
endmodule
`default_nettype wire
